// [design/ipu_pkg.sv]
// Package for the indirect address pointer unit: field positions, codes, reset values.
// Assumes a single 50 MHz core clock and a synchronous active-high core reset.
package ipu_pkg;

    // Widths and depth of the pointer file.
    localparam int unsigned PTR_W = 16;
    localparam int unsigned SEL_W = 3;
    localparam int unsigned NUM_PTR = 8;

    // Field positions inside the instruction word.
    localparam int unsigned IND_BIT = 7;
    localparam int unsigned UPD_HI = 6;
    localparam int unsigned UPD_LO = 4;
    localparam int unsigned SWITCH_BIT = 3;
    localparam int unsigned NEXT_HI = 2;
    localparam int unsigned NEXT_LO = 0;

    // Values after reset.
    localparam logic [15:0] PTR_RST = 16'h0000;
    localparam logic [2:0] SEL_RST = 3'h0;

    // Pointer update codes.
    typedef enum logic [2:0] {
        IPU_UPD_NONE = 3'b000,
        IPU_UPD_DEC = 3'b001,
        IPU_UPD_INC = 3'b010,
        IPU_UPD_RSVD = 3'b011,
        IPU_UPD_SUB_RC = 3'b100,
        IPU_UPD_SUB = 3'b101,
        IPU_UPD_ADD = 3'b110,
        IPU_UPD_ADD_RC = 3'b111
    } ipu_upd_t;

    // Primary operation requested by the decode stage.
    typedef enum logic [2:0] {
        IPU_OP_DATA = 3'b000,
        IPU_OP_LOAD = 3'b001,
        IPU_OP_ADDK = 3'b010,
        IPU_OP_SUBK = 3'b011,
        IPU_OP_MODIFY = 3'b100,
        IPU_OP_IMM = 3'b101
    } ipu_op_t;

    // One decode request from the pipeline.
    typedef struct packed {
        logic valid;
        ipu_op_t op;
        logic [15:0] insn;
        logic [2:0] load_sel;
        logic [15:0] operand;
    } ipu_req_t;

endpackage

// [design/ipu_arith.sv]
// Pointer arithmetic for the indirect address pointer unit.
// Purely combinational; the caller registers the result.
`timescale 1ns/1ps
module ipu_arith (
    // Operands.
    input wire logic [15:0] ptr,
    input wire logic [15:0] index,
    input wire ipu_pkg::ipu_upd_t code,
    // Result.
    output logic [15:0] result
);

    // Bit reversal turns a normal adder into one whose carry runs MSB to LSB.
    function automatic logic [15:0] ipu_rev(input logic [15:0] v);
        logic [15:0] r;
        r = 16'h0000;
        for (int i = 0; i < 16; i++) begin
            r[i] = v[15 - i];
        end
        return r;
    endfunction

    // Select the new pointer value; all sums wrap at 16 bits.
    always_comb begin
        case (code)
            ipu_pkg::IPU_UPD_DEC: result = ptr - 16'h0001;
            ipu_pkg::IPU_UPD_INC: result = ptr + 16'h0001;
            ipu_pkg::IPU_UPD_SUB: result = ptr - index;
            ipu_pkg::IPU_UPD_ADD: result = ptr + index;
            ipu_pkg::IPU_UPD_SUB_RC: result = ipu_rev(ipu_rev(ptr) - ipu_rev(index));
            ipu_pkg::IPU_UPD_ADD_RC: result = ipu_rev(ipu_rev(ptr) + ipu_rev(index));
            default: result = ptr;
        endcase
    end

endmodule

// [design/ipu_top.sv]
// Indirect address pointer unit: eight pointers, select, backup select, data address.
// Assumes the decode stage presents one request per cycle, valid for one cycle.
`timescale 1ns/1ps
module ipu_top (
    // Clock and reset.
    input wire logic clk,
    input wire logic sys_rst,
    // Decode request.
    input wire ipu_pkg::ipu_req_t req,
    input wire logic [15:0] mem_data,
    // Answers.
    output logic [15:0] data_addr,
    output logic addr_valid,
    output logic indirect_refused,
    output logic [2:0] current_pointer_select,
    output logic [2:0] pointer_select_backup,
    output logic [15:0] index_register,
    output logic [15:0] current_pointer
);

    // Pointer file and selection state.
    logic [15:0] ptr_q [8];
    logic [15:0] ptr_d [8];
    logic [2:0] sel_q, sel_d; // Field of the first status word.
    logic [2:0] bak_q, bak_d; // Field of the second status word.
    logic [15:0] addr_q, addr_d;
    logic av_q, av_d;
    logic ref_q, ref_d;

    // Decoded fields.
    logic ind;
    ipu_pkg::ipu_upd_t code;
    logic sw;
    logic [2:0] nxt;
    logic [15:0] cur;
    logic [15:0] upd;

    // The upper byte is left to the pipeline; only the low byte is decoded here.
    assign ind = req.insn[ipu_pkg::IND_BIT];
    assign code = ipu_pkg::ipu_upd_t'(req.insn[ipu_pkg::UPD_HI:ipu_pkg::UPD_LO]);
    assign sw = req.insn[ipu_pkg::SWITCH_BIT];
    assign nxt = req.insn[ipu_pkg::NEXT_HI:ipu_pkg::NEXT_LO];
    assign cur = ptr_q[sel_q];

    // Shared arithmetic on the current pointer with the index register.
    ipu_arith u_arith (
        .ptr(cur),
        .index(ptr_q[0]),
        .code(code),
        .result(upd)
    );

    // Next-state logic: all updates land at the end of the decode cycle.
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            ptr_d[i] = ptr_q[i];
        end
        sel_d = sel_q;
        bak_d = bak_q;
        addr_d = addr_q;
        av_d = 1'b0;
        ref_d = 1'b0;
        if (req.valid) begin
            case (req.op)
                ipu_pkg::IPU_OP_LOAD: begin
                    // Memory value goes to the named pointer; the operand mode is handled
                    // by the pipeline, which presents the fetched value here.
                    ptr_d[req.load_sel] = mem_data;
                end
                ipu_pkg::IPU_OP_ADDK: begin
                    ptr_d[sel_q] = cur + req.operand;
                end
                ipu_pkg::IPU_OP_SUBK: begin
                    ptr_d[sel_q] = cur - req.operand;
                end
                ipu_pkg::IPU_OP_IMM: begin
                    // Immediate forms have no pointer operand; a set bit 7 is refused through indirect_refused.
                    ref_d = ind;
                end
                default: begin
                    // Data access and modify-pointer share the indirect path.
                    if (ind) begin
                        if (req.op != ipu_pkg::IPU_OP_MODIFY) begin
                            addr_d = cur;
                            av_d = 1'b1;
                        end
                        ptr_d[sel_q] = upd;
                        if (sw) begin
                            bak_d = sel_q;
                            sel_d = nxt;
                        end else begin
                            sel_d = sel_q;
                        end
                    end
                end
            endcase
        end
    end

    // Register stage; the reset clears every pointer and both select fields.
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            for (int i = 0; i < 8; i++) begin
                ptr_q[i] <= ipu_pkg::PTR_RST;
            end
            sel_q <= ipu_pkg::SEL_RST;
            bak_q <= ipu_pkg::SEL_RST;
            addr_q <= ipu_pkg::PTR_RST;
            av_q <= 1'b0;
            ref_q <= 1'b0;
        end else begin
            for (int i = 0; i < 8; i++) begin
                ptr_q[i] <= ptr_d[i];
            end
            sel_q <= sel_d;
            bak_q <= bak_d;
            addr_q <= addr_d;
            av_q <= av_d;
            ref_q <= ref_d;
        end
    end

    // Outputs straight from flip-flops; current pointer tracks the register file.
    logic [15:0] curo_q;
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            curo_q <= ipu_pkg::PTR_RST;
        end else begin
            curo_q <= ptr_d[sel_d];
        end
    end

    assign data_addr = addr_q;
    assign addr_valid = av_q;
    assign indirect_refused = ref_q;
    assign current_pointer_select = sel_q;
    assign pointer_select_backup = bak_q;
    assign index_register = ptr_q[0];
    assign current_pointer = curo_q;

    // Checks on the indirect path.
    logic [15:0] cur_past;
    assign cur_past = cur;

    // Indirect access or modify that keeps the select, so current_pointer shows the update.
    logic ind_keep;
    assign ind_keep = req.valid && ind && !sw
        && (req.op == ipu_pkg::IPU_OP_DATA || req.op == ipu_pkg::IPU_OP_MODIFY);

    sequence ind_access_s;
        req.valid && ind && req.op == ipu_pkg::IPU_OP_DATA;
    endsequence

    sequence switch_s;
        req.valid && ind && sw && req.op inside {ipu_pkg::IPU_OP_DATA, ipu_pkg::IPU_OP_MODIFY};
    endsequence

    addr_before_update_a: assert property (@(posedge clk) disable iff (sys_rst)
        ind_access_s |=> addr_valid && data_addr == $past(cur_past))
        else $error("Data address is not the pre-update pointer.");

    select_switch_a: assert property (@(posedge clk) disable iff (sys_rst)
        switch_s |=> current_pointer_select == $past(nxt)
            && pointer_select_backup == $past(sel_q))
        else $error("Pointer select switch failed.");

    select_hold_a: assert property (@(posedge clk) disable iff (sys_rst)
        req.valid && ind && !sw && req.op == ipu_pkg::IPU_OP_DATA
            |=> $stable(current_pointer_select))
        else $error("Pointer select changed without switch bit.");

    inc_one_a: assert property (@(posedge clk) disable iff (sys_rst)
        ind_keep && code == ipu_pkg::IPU_UPD_INC
            |=> current_pointer == $past(cur) + 16'h0001)
        else $error("Increment by one missing.");

    // Decrement by one wraps below zero like every other pointer sum.
    dec_one_a: assert property (@(posedge clk) disable iff (sys_rst)
        ind_keep && code == ipu_pkg::IPU_UPD_DEC
            |=> current_pointer == $past(cur) - 16'h0001)
        else $error("Decrement by one missing.");

    no_change_a: assert property (@(posedge clk) disable iff (sys_rst)
        ind_keep && (code == ipu_pkg::IPU_UPD_NONE || code == ipu_pkg::IPU_UPD_RSVD)
            |=> current_pointer == $past(cur))
        else $error("Pointer changed for a no-update code.");

    // Pointer 0 is left out so that the index seen after the edge is the one that was used.
    sub_index_a: assert property (@(posedge clk) disable iff (sys_rst)
        ind_keep && code == ipu_pkg::IPU_UPD_SUB && sel_q != 3'h0
            |=> current_pointer == $past(cur) - index_register)
        else $error("Index subtraction wrong.");

    add_index_a: assert property (@(posedge clk) disable iff (sys_rst)
        ind_keep && code == ipu_pkg::IPU_UPD_ADD && sel_q != 3'h0
            |=> current_pointer == $past(cur) + index_register)
        else $error("Index addition wrong.");

    // Reverse carry: the top bit takes no carry in, the next bit takes the top bit's carry.
    rc_add_msb_a: assert property (@(posedge clk) disable iff (sys_rst)
        ind_keep && code == ipu_pkg::IPU_UPD_ADD_RC && sel_q != 3'h0
            |=> current_pointer[15] == ($past(cur[15]) ^ index_register[15])
            && current_pointer[14] == ($past(cur[14]) ^ index_register[14]
                ^ ($past(cur[15]) & index_register[15])))
        else $error("Reverse-carry add does not carry toward the low bits.");

    // The borrow of a reverse-carry subtraction also runs from the top bit downward.
    rc_sub_msb_a: assert property (@(posedge clk) disable iff (sys_rst)
        ind_keep && code == ipu_pkg::IPU_UPD_SUB_RC && sel_q != 3'h0
            |=> current_pointer[15] == ($past(cur[15]) ^ index_register[15])
            && current_pointer[14] == ($past(cur[14]) ^ index_register[14]
                ^ (~$past(cur[15]) & index_register[15])))
        else $error("Reverse-carry subtract does not borrow toward the low bits.");

    imm_refuse_a: assert property (@(posedge clk) disable iff (sys_rst)
        req.valid && req.op == ipu_pkg::IPU_OP_IMM && ind |=> indirect_refused && !addr_valid)
        else $error("Immediate form took an indirect operand.");

    // Immediate forms leave pointer, select and address exactly as they were.
    imm_no_side_a: assert property (@(posedge clk) disable iff (sys_rst)
        req.valid && req.op == ipu_pkg::IPU_OP_IMM
            |=> $stable(current_pointer) && $stable(current_pointer_select) && $stable(data_addr))
        else $error("Immediate form changed the pointer state.");

    modify_no_access_a: assert property (@(posedge clk) disable iff (sys_rst)
        req.valid && req.op == ipu_pkg::IPU_OP_MODIFY |=> !addr_valid)
        else $error("Modify-pointer made a data access.");

    // A load into pointer 0 shows on the index output one edge later.
    load_index_a: assert property (@(posedge clk) disable iff (sys_rst)
        req.valid && req.op == ipu_pkg::IPU_OP_LOAD && req.load_sel == 3'h0
            |=> index_register == $past(mem_data))
        else $error("Load-pointer did not write the chosen pointer.");

    // Constant forms work on the current pointer with plain wrapping arithmetic.
    add_const_a: assert property (@(posedge clk) disable iff (sys_rst)
        req.valid && req.op == ipu_pkg::IPU_OP_ADDK
            |=> current_pointer == $past(cur) + $past(req.operand))
        else $error("Add-constant result wrong.");

    sub_const_a: assert property (@(posedge clk) disable iff (sys_rst)
        req.valid && req.op == ipu_pkg::IPU_OP_SUBK
            |=> current_pointer == $past(cur) - $past(req.operand))
        else $error("Subtract-constant result wrong.");

endmodule

// [tb/ipu_feed.sv]
// Model of the decode pipeline that hands the pointer unit one request per edge.
// Assumes a free-running core clock and that the caller waits out reset first.
`timescale 1ns/1ps
module ipu_feed (
    // Clock.
    input wire logic clk,
    // Request towards the unit.
    output ipu_pkg::ipu_req_t req,
    output logic [15:0] mem_data
);
    // Changes land 2 ns after an edge, so the next edge samples them cleanly.
    task automatic send(input ipu_pkg::ipu_req_t r, input logic [15:0] m);
        @(posedge clk);
        #2;
        req = r;
        mem_data = m;
    endtask

    // Idle until the first request.
    initial begin
        req = '0;
        mem_data = 16'h0000;
    end
endmodule

// [tb/ipu_top_test.sv]
// Self-checking bench for the pointer unit, with a reference model of the pointer file.
// Assumes the unit answers every request one edge after it is taken.
`timescale 1ns/1ps
module ipu_top_test;
    // One expected answer, due after the given edge count.
    typedef struct {int due; logic av, rf; logic [15:0] da, cp, ix; logic [2:0] cs, bk;} ipu_note_t;
    logic clk = 1'b0;
    logic sys_rst;
    ipu_pkg::ipu_req_t req;
    logic [15:0] mem_data, data_addr, index_register, current_pointer;
    logic addr_valid, indirect_refused;
    logic [2:0] current_pointer_select, pointer_select_backup, sel, bak, o;
    logic [15:0] p [8];
    logic [15:0] w;
    logic [31:0] lfsr_q = 32'h00013F7C;
    ipu_note_t notes [$];
    ipu_note_t m;
    int cyc = 0;
    int fail_count = 0;
    int check_count = 0;

    // Clock at 50 MHz and an edge counter for note timing.
    always #10 clk = ~clk;
    always @(posedge clk) cyc++;

    ipu_feed feed (.clk(clk), .req(req), .mem_data(mem_data));
    ipu_top dut (.clk(clk), .sys_rst(sys_rst), .req(req), .mem_data(mem_data),
        .data_addr(data_addr), .addr_valid(addr_valid), .indirect_refused(indirect_refused),
        .current_pointer_select(current_pointer_select),
        .pointer_select_backup(pointer_select_backup),
        .index_register(index_register), .current_pointer(current_pointer));

    function automatic logic [31:0] lfsr_next(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    // Bit reversal, so reverse carry becomes a plain add on mirrored values.
    function automatic logic [15:0] rev(input logic [15:0] v);
        for (int i = 0; i < 16; i++) rev[i] = v[15 - i];
    endfunction

    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        check_count++;
        if (got !== exp) begin
            fail_count++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask

    // Update the model, send the request and note what must appear one edge later.
    task automatic issue(input logic [2:0] op, input logic [15:0] insn, input logic [2:0] ls,
        input logic [15:0] opd, input logic [15:0] md);
        ipu_note_t n;
        logic [15:0] c, x;
        c = p[sel];
        x = p[0];
        n.av = (op == 3'h0) && insn[7];
        n.rf = (op == 3'h5) && insn[7];
        n.da = c;
        if (op == 3'h1) p[ls] = md;
        if (op == 3'h2) p[sel] = c + opd;
        if (op == 3'h3) p[sel] = c - opd;
        if ((op == 3'h0 || op == 3'h4) && insn[7]) begin
            case (insn[6:4])
                3'h1: p[sel] = c - 16'h0001;
                3'h2: p[sel] = c + 16'h0001;
                3'h4: p[sel] = rev(rev(c) - rev(x));
                3'h5: p[sel] = c - x;
                3'h6: p[sel] = c + x;
                3'h7: p[sel] = rev(rev(c) + rev(x));
                default: ;
            endcase
            if (insn[3]) begin
                bak = sel;
                sel = insn[2:0];
            end
        end
        n.cs = sel;
        n.bk = bak;
        n.cp = p[sel];
        n.ix = p[0];
        feed.send({1'b1, op, insn, ls, opd}, md);
        n.due = cyc + 1;
        notes.push_back(n);
    endtask

    // Monitor: compares the oldest note at the falling edge after its answer lands.
    always @(negedge clk) begin
        if (notes.size() > 0 && notes[0].due == cyc) begin
            m = notes.pop_front();
            chk("addr_valid", {15'h0000, m.av}, {15'h0000, addr_valid});
            chk("refused", {15'h0000, m.rf}, {15'h0000, indirect_refused});
            if (m.av) chk("data_addr", m.da, data_addr);
            chk("select", {13'h0000, m.cs}, {13'h0000, current_pointer_select});
            chk("backup", {13'h0000, m.bk}, {13'h0000, pointer_select_backup});
            chk("pointer", m.cp, current_pointer);
            chk("index", m.ix, index_register);
        end
    end

    task automatic final_report;
        $display("checks %0d failures %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // Watchdog sized well past the roughly 340 cycles the tests need.
    initial begin
        #40000;
        fail_count++;
        final_report();
    end

    initial begin
        sys_rst = 1'b1;
        for (int i = 0; i < 8; i++) p[i] = 16'h0000;
        sel = 3'h0;
        bak = 3'h0;
        repeat (5) @(posedge clk);
        #2;
        sys_rst = 1'b0;
        @(negedge clk);
        chk("rst pointer", 16'h0000, current_pointer);
        chk("rst select", 16'h0000, {13'h0000, current_pointer_select});
        $display("reset test done");
        // Seed two pointers, then walk every update code back to back.
        issue(3'h1, 16'h0000, 3'h0, 16'h0000, 16'h0102);
        issue(3'h1, 16'h0000, 3'h1, 16'h0000, 16'hFFF0);
        issue(3'h0, 16'hFFA9, 3'h0, 16'h0000, 16'h0000);
        for (int k = 0; k < 16; k++) begin
            w = {8'hA5, 1'b1, k[3:0], 3'h1};
            issue({~k[0], 2'b00}, w, 3'h0, 16'h0000, 16'h0000);
        end
        issue(3'h5, 16'h0080, 3'h0, 16'h0000, 16'h0000);
        issue(3'h2, 16'h0000, 3'h0, 16'h8001, 16'h0000);
        issue(3'h3, 16'h0000, 3'h0, 16'hC003, 16'h0000);
        $display("directed test done");
        // Random traffic; the constant and load forms never carry an indirect bit.
        repeat (300) begin
            lfsr_q = lfsr_next(lfsr_q);
            o = (lfsr_q[2:0] > 3'h5) ? 3'h0 : lfsr_q[2:0];
            w = lfsr_q[31:16];
            if (o != 3'h0 && o < 3'h4) w[7] = 1'b0;
            lfsr_q = lfsr_next(lfsr_q);
            issue(o, w, lfsr_q[5:3], lfsr_q[31:16], lfsr_q[15:0]);
        end
        feed.send('0, 16'hFFFF);
        repeat (3) @(negedge clk);
        $display("random test done");
        // A reset in mid-run is checked on pointers 0 and 2 and on both select fields.
        @(posedge clk);
        #2;
        sys_rst = 1'b1;
        repeat (2) @(posedge clk);
        #2;
        sys_rst = 1'b0;
        for (int i = 0; i < 8; i++) p[i] = 16'h0000;
        sel = 3'h0;
        bak = 3'h0;
        @(negedge clk);
        chk("rst index", 16'h0000, index_register);
        chk("rst backup", 16'h0000, {13'h0000, pointer_select_backup});
        issue(3'h0, 16'h00BA, 3'h0, 16'h0000, 16'h0000);
        feed.send('0, 16'h0000);
        repeat (2) @(negedge clk);
        // Every noted answer must have been compared by now.
        chk("pending notes", 16'h0000, 16'(notes.size()));
        $display("mid-run reset test done");
        final_report();
    end
endmodule
